// ===== verilog/otl_regs.svh
// Register map, field positions, reset values and codes of the overtravel and torque limit block.
// Assumes a 32-bit APB master; all offsets are byte addresses of aligned words.
`ifndef OTL_REGS_SVH
`define OTL_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define OTL_CTRL 8'h00
`define OTL_TLIM 8'h04
`define OTL_ESTOP 8'h08
`define OTL_STATUS 8'h0C
`define OTL_ISTAT 8'h10
`define OTL_IMASK 8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OTL_CTRL_W 15
`define OTL_STAT_W 9
`define OTL_HI_LSB 16
`define OTL_LIM_W 10
`define OTL_EV_W 4

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define OTL_MAP_OFF 4'h8
`define OTL_MAP_FWD 4'h2
`define OTL_MAP_REV 4'h3
`define OTL_MAP_FWD_INV 4'hB
`define OTL_MAP_REV_INV 4'hC
`define OTL_MODE_SVOFF 2'h0
`define OTL_MODE_CLAMP 2'h1
`define OTL_MODE_COAST 2'h2
`define OTL_METHOD_BRAKE 2'h0
`define OTL_LIM_RST 10'h320
`define OTL_TERM_NONE 2'h0

`endif

// ===== verilog/otl_pkg.sv
// Types of the overtravel and torque limit block.
// Assumes otl_regs.svh supplies the numeric constants.
`include "otl_regs.svh"
package otl_pkg;

  typedef enum logic [2:0] {RUN, SVOFF, DECEL, CLAMP, COAST} stop_t;

  typedef struct packed {
    logic [1:0] termSel;
    logic torqueMode;
    logic [1:0] servoOffStopMethod;
    logic [1:0] overtravelStopMode;
    logic [3:0] revLimitMapping;
    logic [3:0] fwdLimitMapping;
  } ctrl_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    ctrl_t ctrl;
    logic [`OTL_LIM_W-1:0] fwdLim;
    logic [`OTL_LIM_W-1:0] revLim;
    logic [`OTL_LIM_W-1:0] estop;
    logic [`OTL_LIM_W-1:0] motorMax;
    logic [`OTL_EV_W-1:0] irqStat;
    logic [`OTL_EV_W-1:0] irqMask;
    logic fwdS1;
    logic fwdS2;
    logic revS1;
    logic revS2;
    logic fwdOtQ;
    logic revOtQ;
    logic limQ;
    logic stopDir;
    stop_t state;
    logic signed [11:0] torqueOut;
    logic fwdAllowed;
    logic revAllowed;
    logic limitActive;
    logic [2:0] terminals;
    logic driveOn;
    logic brakeOn;
    logic zeroClamp;
    logic irq;
    apb_rsp_t rsp;
  } st_t;

endpackage

// ===== verilog/overtravel_and_torque_limit.sv
// Overtravel stop sequencing and torque clamping of the servo drive, with APB registers.
// Assumes torque reference, motion direction and standstill come from the same clock domain;
// limit switch inputs are asynchronous pins.
`timescale 1ns/1ps
`include "otl_regs.svh"
module overtravel_and_torque_limit (
  input wire logic clk,
  input wire logic resetn,
  input otl_pkg::apb_req_t apbReq,
  output otl_pkg::apb_rsp_t apbRsp,
  input wire logic fwdTravelLimitIn,
  input wire logic revTravelLimitIn,
  input wire logic signed [11:0] torqueRef,
  input wire logic moveFwd,
  input wire logic moveRev,
  input wire logic motorStopped,
  output logic signed [11:0] torqueOut,
  output logic fwdAllowed,
  output logic revAllowed,
  output logic limitActive,
  output logic [2:0] outputCircuits,
  output logic driveOn,
  output logic brakeOn,
  output logic zeroClamp,
  output logic irq
);

  otl_pkg::st_t s_ff;
  otl_pkg::st_t nxt_s;
  logic fwdOt;
  logic revOt;
  logic [`OTL_LIM_W-1:0] fwdEff;
  logic [`OTL_LIM_W-1:0] revEff;
  logic [`OTL_LIM_W-1:0] estopEff;
  logic signed [11:0] fwdS;
  logic signed [11:0] revS;
  logic signed [11:0] estopS;
  logic signed [11:0] clamped;
  logic limAct;
  logic commit;
  logic [`OTL_EV_W-1:0] ev;
  logic [`OTL_EV_W-1:0] clr;
  logic [31:0] rdata;
  logic mapped;

  // ----------------------------------------
  // Input mapping
  // ----------------------------------------
  always_comb
  begin
    case (s_ff.ctrl.fwdLimitMapping)
      `OTL_MAP_FWD: fwdOt = s_ff.fwdS2;
      `OTL_MAP_FWD_INV: fwdOt = ~s_ff.fwdS2;
      default: fwdOt = 1'b0;
    endcase
    case (s_ff.ctrl.revLimitMapping)
      `OTL_MAP_REV: revOt = s_ff.revS2;
      `OTL_MAP_REV_INV: revOt = ~s_ff.revS2;
      default: revOt = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Effective limits and clamp
  // ----------------------------------------
  always_comb
  begin
    fwdEff = (s_ff.fwdLim > s_ff.motorMax) ? s_ff.motorMax : s_ff.fwdLim;
    revEff = (s_ff.revLim > s_ff.motorMax) ? s_ff.motorMax : s_ff.revLim;
    estopEff = (s_ff.estop > s_ff.motorMax) ? s_ff.motorMax : s_ff.estop;
    fwdS = $signed({2'b00, fwdEff});
    revS = $signed({2'b00, revEff});
    estopS = $signed({2'b00, estopEff});
    // Checked on every cycle, also during a stop sequence
    limAct = (torqueRef > fwdS) || (torqueRef < -revS);
    if (torqueRef > fwdS)
    begin
      clamped = fwdS;
    end
    else if (torqueRef < -revS)
    begin
      clamped = -revS;
    end
    else
    begin
      clamped = torqueRef;
    end
    // Blocked direction gets no torque; the other side still passes
    if (fwdOt && clamped > 12'sh000)
    begin
      clamped = 12'sh000;
    end
    if (revOt && clamped < 12'sh000)
    begin
      clamped = 12'sh000;
    end
  end

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  always_comb
  begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    case (apbReq.paddr)
      `OTL_CTRL: rdata[`OTL_CTRL_W-1:0] = s_ff.ctrl;
      `OTL_TLIM:
      begin
        rdata[`OTL_LIM_W-1:0] = s_ff.fwdLim;
        rdata[`OTL_HI_LSB +: `OTL_LIM_W] = s_ff.revLim;
      end
      `OTL_ESTOP:
      begin
        rdata[`OTL_LIM_W-1:0] = s_ff.estop;
        rdata[`OTL_HI_LSB +: `OTL_LIM_W] = s_ff.motorMax;
      end
      // Output signal monitor view
      `OTL_STATUS: rdata[`OTL_STAT_W-1:0] = {s_ff.terminals, s_ff.state, s_ff.limitActive, s_ff.revOtQ, s_ff.fwdOtQ};
      `OTL_ISTAT: rdata[`OTL_EV_W-1:0] = s_ff.irqStat;
      `OTL_IMASK: rdata[`OTL_EV_W-1:0] = s_ff.irqMask;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nxt_s = s_ff;
    commit = apbReq.psel && apbReq.penable && s_ff.rsp.pready;
    // Ready one cycle into the access phase; write and read-clear land on the next edge, where ready is sampled high
    nxt_s.rsp.pready = apbReq.psel && apbReq.penable && !s_ff.rsp.pready;
    nxt_s.rsp.pslverr = nxt_s.rsp.pready && !mapped;
    if (nxt_s.rsp.pready)
    begin
      nxt_s.rsp.prdata = apbReq.pwrite ? 32'h0000_0000 : rdata;
    end
    if (commit && apbReq.pwrite)
    begin
      case (apbReq.paddr)
        `OTL_CTRL: nxt_s.ctrl = apbReq.pwdata[`OTL_CTRL_W-1:0];
        `OTL_TLIM:
        begin
          nxt_s.fwdLim = apbReq.pwdata[`OTL_LIM_W-1:0];
          nxt_s.revLim = apbReq.pwdata[`OTL_HI_LSB +: `OTL_LIM_W];
        end
        `OTL_ESTOP:
        begin
          nxt_s.estop = apbReq.pwdata[`OTL_LIM_W-1:0];
          nxt_s.motorMax = apbReq.pwdata[`OTL_HI_LSB +: `OTL_LIM_W];
        end
        `OTL_IMASK: nxt_s.irqMask = apbReq.pwdata[`OTL_EV_W-1:0];
        default: ;
      endcase
    end

    // Pins reach the mapping only after both stages
    nxt_s.fwdS1 = fwdTravelLimitIn;
    nxt_s.fwdS2 = s_ff.fwdS1;
    nxt_s.revS1 = revTravelLimitIn;
    nxt_s.revS2 = s_ff.revS1;
    nxt_s.fwdOtQ = fwdOt;
    nxt_s.revOtQ = revOt;
    nxt_s.limQ = limAct;

    case (s_ff.state)
      otl_pkg::RUN:
      begin
        if ((fwdOt && moveFwd) || (revOt && moveRev))
        begin
          nxt_s.stopDir = fwdOt && moveFwd;
          // Torque control ignores the stop mode
          if (s_ff.ctrl.torqueMode || s_ff.ctrl.overtravelStopMode == `OTL_MODE_SVOFF)
          begin
            nxt_s.state = otl_pkg::SVOFF;
          end
          else
          begin
            nxt_s.state = otl_pkg::DECEL;
          end
        end
      end
      otl_pkg::SVOFF:
      begin
        if (s_ff.ctrl.torqueMode && motorStopped)
        begin
          nxt_s.state = otl_pkg::COAST;
        end
        else if (!(s_ff.stopDir ? fwdOt : revOt))
        begin
          nxt_s.state = otl_pkg::RUN;
        end
      end
      otl_pkg::DECEL:
      begin
        if (motorStopped)
        begin
          nxt_s.state = (s_ff.ctrl.overtravelStopMode == `OTL_MODE_CLAMP) ? otl_pkg::CLAMP : otl_pkg::COAST;
        end
      end
      otl_pkg::CLAMP, otl_pkg::COAST:
      begin
        // Leave once the switch in the stopped direction releases
        if (!(s_ff.stopDir ? fwdOt : revOt))
        begin
          nxt_s.state = otl_pkg::RUN;
        end
      end
      default: nxt_s.state = otl_pkg::RUN;
    endcase

    case (nxt_s.state)
      otl_pkg::RUN: nxt_s.torqueOut = clamped;
      otl_pkg::DECEL: nxt_s.torqueOut = nxt_s.stopDir ? -estopS : estopS;
      default: nxt_s.torqueOut = 12'sh000;
    endcase
    nxt_s.driveOn = nxt_s.state == otl_pkg::RUN || nxt_s.state == otl_pkg::DECEL || nxt_s.state == otl_pkg::CLAMP;
    nxt_s.zeroClamp = nxt_s.state == otl_pkg::CLAMP;
    nxt_s.brakeOn = nxt_s.state == otl_pkg::SVOFF && s_ff.ctrl.servoOffStopMethod == `OTL_METHOD_BRAKE;
    nxt_s.fwdAllowed = !fwdOt;
    nxt_s.revAllowed = !revOt;
    nxt_s.limitActive = limAct;
    nxt_s.terminals = 3'b000;
    if (s_ff.ctrl.termSel != `OTL_TERM_NONE)
    begin
      nxt_s.terminals[s_ff.ctrl.termSel - 2'd1] = limAct;
    end

    // Events: each limit rising, limit-active rising, stop sequence done
    ev = {(s_ff.state == otl_pkg::DECEL || s_ff.state == otl_pkg::SVOFF) && motorStopped,
          limAct && !s_ff.limQ, revOt && !s_ff.revOtQ, fwdOt && !s_ff.fwdOtQ};
    // Only bits already returned are cleared; a later event stays pending
    clr = (commit && !apbReq.pwrite && apbReq.paddr == `OTL_ISTAT) ? s_ff.rsp.prdata[`OTL_EV_W-1:0] : 4'h0;
    // Set wins over a read-clear in the same cycle
    nxt_s.irqStat = (s_ff.irqStat & ~clr) | ev;
    nxt_s.irq = |(nxt_s.irqStat & nxt_s.irqMask);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_ff <= '0;
      s_ff.ctrl.fwdLimitMapping <= `OTL_MAP_OFF;
      s_ff.ctrl.revLimitMapping <= `OTL_MAP_OFF;
      s_ff.ctrl.overtravelStopMode <= `OTL_MODE_SVOFF;
      s_ff.fwdLim <= `OTL_LIM_RST;
      s_ff.revLim <= `OTL_LIM_RST;
      s_ff.estop <= `OTL_LIM_RST;
      s_ff.motorMax <= `OTL_LIM_RST;
      s_ff.state <= otl_pkg::RUN;
      s_ff.fwdAllowed <= 1'b1;
      s_ff.revAllowed <= 1'b1;
      s_ff.driveOn <= 1'b1;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign apbRsp = s_ff.rsp;
  assign torqueOut = s_ff.torqueOut;
  assign fwdAllowed = s_ff.fwdAllowed;
  assign revAllowed = s_ff.revAllowed;
  assign limitActive = s_ff.limitActive;
  assign outputCircuits = s_ff.terminals;
  assign driveOn = s_ff.driveOn;
  assign brakeOn = s_ff.brakeOn;
  assign zeroClamp = s_ff.zeroClamp;
  assign irq = s_ff.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_fwd_torque_block: assert property (fwdOt && nxt_s.state == otl_pkg::RUN |=> torqueOut <= 12'sh000)
    else $error("forward torque passed while forward blocked");
  a_rev_torque_block: assert property (revOt && nxt_s.state == otl_pkg::RUN |=> torqueOut >= 12'sh000)
    else $error("reverse torque passed while reverse blocked");
  a_map_ignore: assert property (s_ff.ctrl.fwdLimitMapping == `OTL_MAP_OFF |=> fwdAllowed)
    else $error("ignored forward input blocked motion");
  a_map_direct_fwd: assert property (s_ff.ctrl.fwdLimitMapping == `OTL_MAP_FWD && s_ff.fwdS2 |=> !fwdAllowed)
    else $error("forward open input did not block");
  a_map_direct_rev: assert property (s_ff.ctrl.revLimitMapping == `OTL_MAP_REV && !s_ff.revS2 |=> revAllowed)
    else $error("reverse input at 0V blocked motion");
  a_map_invert_fwd: assert property (s_ff.ctrl.fwdLimitMapping == `OTL_MAP_FWD_INV |-> fwdOt == !s_ff.fwdS2)
    else $error("forward inverted sense wrong");
  a_map_invert_rev: assert property (s_ff.ctrl.revLimitMapping == `OTL_MAP_REV_INV |-> revOt == !s_ff.revS2)
    else $error("reverse inverted sense wrong");
  a_svoff_drive: assert property (nxt_s.state == otl_pkg::SVOFF |=> !driveOn && torqueOut == 12'sh000)
    else $error("servo-off stop still drives");
  a_clamp_after: assert property (s_ff.state == otl_pkg::DECEL && motorStopped
    && s_ff.ctrl.overtravelStopMode == `OTL_MODE_CLAMP |=> zeroClamp && driveOn)
    else $error("no zero clamp after deceleration");
  a_coast_after: assert property (s_ff.state == otl_pkg::DECEL && motorStopped
    && s_ff.ctrl.overtravelStopMode == `OTL_MODE_COAST |=> !driveOn ##1 !zeroClamp)
    else $error("no coast after deceleration");
  a_torque_coast: assert property (s_ff.ctrl.torqueMode && s_ff.state == otl_pkg::SVOFF
    && motorStopped |=> s_ff.state == otl_pkg::COAST && !zeroClamp)
    else $error("torque control stop did not coast");
  a_estop_torque: assert property (nxt_s.state == otl_pkg::DECEL && nxt_s.stopDir
    |=> torqueOut == -$past(estopS))
    else $error("deceleration torque wrong");
  a_limit_clamp: assert property (nxt_s.state == otl_pkg::RUN |=> torqueOut <= $past(fwdS))
    else $error("forward limit exceeded");
  a_terminal_out: assert property (limAct && s_ff.ctrl.termSel != `OTL_TERM_NONE |=> outputCircuits != 3'b000)
    else $error("limit-active missing on selected terminal");
  a_cap_max: assert property (fwdEff <= s_ff.motorMax && revEff <= s_ff.motorMax)
    else $error("limit above motor maximum");
  a_limit_flag: assert property (torqueRef > fwdS |=> limitActive)
    else $error("limit-active not raised");
  a_sync_delay: assert property ($past(resetn) && $past(resetn, 2)
    |-> s_ff.fwdS2 == $past(fwdTravelLimitIn, 2))
    else $error("travel input not two-stage synchronised");

  a_terminal_clear: assert property (!limAct |=> outputCircuits == 3'b000)
    else $error("terminal set without limit");
  a_limit_off: assert property (torqueRef <= fwdS && torqueRef >= -revS
    |=> !limitActive)
    else $error("limit-active raised inside limits");
  a_rev_open_block: assert property (s_ff.ctrl.revLimitMapping == `OTL_MAP_REV
    && s_ff.revS2 |=> !revAllowed)
    else $error("reverse open input did not block");

  // Stop sequence
  a_stop_entry: assert property (s_ff.state == otl_pkg::RUN && fwdOt && moveFwd
    |=> s_ff.state != otl_pkg::RUN)
    else $error("forward overtravel did not start a stop");
  a_decel_hold: assert property (s_ff.state == otl_pkg::DECEL && !motorStopped
    |=> s_ff.state == otl_pkg::DECEL)
    else $error("deceleration left before standstill");
  a_rev_decel: assert property (nxt_s.state == otl_pkg::DECEL && !nxt_s.stopDir
    |=> torqueOut == $past(estopS))
    else $error("reverse deceleration torque wrong");
  a_hold_release: assert property ((s_ff.state == otl_pkg::CLAMP || s_ff.state == otl_pkg::COAST)
    && !(s_ff.stopDir ? fwdOt : revOt) |=> s_ff.state == otl_pkg::RUN)
    else $error("stop held after the limit released");

  // ----------------------------------------
  // Bus and event assertions
  // ----------------------------------------
  // One wait state: ready follows the first access cycle and lasts one cycle
  a_ready_one_wait: assert property (apbReq.psel && apbReq.penable && !apbRsp.pready |=> apbRsp.pready)
    else $error("ready missing after first access cycle");
  a_ready_pulse: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("error response without ready");
  a_err_unmapped: assert property (nxt_s.rsp.pready && !mapped |=> apbRsp.pslverr)
    else $error("unmapped address accepted");
  // A read-clear must not swallow an event raised in the same cycle
  a_set_wins: assert property (ev[2] |=> s_ff.irqStat[2])
    else $error("limit event not recorded");
  a_event_sticky: assert property (s_ff.irqStat[2] && !clr[2] |=> s_ff.irqStat[2])
    else $error("limit event bit lost");
  a_irq_level: assert property (irq == |(s_ff.irqStat & s_ff.irqMask))
    else $error("interrupt level wrong");

  c_decel_clamp: cover property (s_ff.state == otl_pkg::DECEL ##1 s_ff.state == otl_pkg::CLAMP);
  c_torque_coast: cover property (s_ff.state == otl_pkg::SVOFF ##1 s_ff.state == otl_pkg::COAST);
  c_limit_irq: cover property (limitActive && irq);
  c_rev_decel: cover property (nxt_s.state == otl_pkg::DECEL && !nxt_s.stopDir);
  c_clear_event: cover property (clr != 4'h0);

endmodule // overtravel_and_torque_limit

// ===== tb/limit_switch_model.sv
// Pair of travel-limit switches wired to the drive's limit pins.
// Assumes the bench presses switches by level; contacts are taken as bounce free.
`timescale 1ns/1ps
module limit_switch_model (
  input wire logic fwdPressed,
  input wire logic revPressed,
  input wire logic normallyOpen,
  output logic fwdTravelLimitIn,
  output logic revTravelLimitIn
);
  // --------------------------------------------------------
  // Contacts
  // --------------------------------------------------------
  // Open contact reads high through the pin pull-up, so a pressed
  // normally closed switch and a released normally open one read high
  assign fwdTravelLimitIn = fwdPressed ^ normallyOpen;
  assign revTravelLimitIn = revPressed ^ normallyOpen;
endmodule // limit_switch_model

// ===== tb/tb.sv
// Self-checking bench of the overtravel and torque limit block.
// Assumes one 40 MHz clock; registers reached over APB, switches through limit_switch_model.
`timescale 1ns/1ps
`include "otl_regs.svh"
module tb;
  // --------------------------------------------------------
  // Signals
  // --------------------------------------------------------
  logic clk;
  logic resetn;
  otl_pkg::apb_req_t apbReq;
  otl_pkg::apb_rsp_t apbRsp;
  logic fwdTravelLimitIn, revTravelLimitIn, fwdPressed, revPressed, normallyOpen;
  logic signed [11:0] torqueRef;
  logic signed [11:0] torqueOut;
  logic moveFwd, moveRev, motorStopped, fwdAllowed, revAllowed, limitActive;
  logic driveOn, brakeOn, zeroClamp, irq;
  logic [2:0] outputCircuits;
  logic rev, no, pr, dec, tq, e;
  logic [1:0] md;
  logic [3:0] m;
  logic [31:0] q;
  int err_total = 0;
  int comparisons = 0;
  int refTab [4] = '{250, 200, -350, -100};
  int outTab [4] = '{200, 200, -300, -100};

  overtravel_and_torque_limit u_overtravel_and_torque_limit (.clk(clk), .resetn(resetn), .apbReq(apbReq),
    .apbRsp(apbRsp), .fwdTravelLimitIn(fwdTravelLimitIn), .revTravelLimitIn(revTravelLimitIn),
    .torqueRef(torqueRef), .moveFwd(moveFwd), .moveRev(moveRev), .motorStopped(motorStopped),
    .torqueOut(torqueOut), .fwdAllowed(fwdAllowed), .revAllowed(revAllowed), .limitActive(limitActive),
    .outputCircuits(outputCircuits), .driveOn(driveOn), .brakeOn(brakeOn), .zeroClamp(zeroClamp), .irq(irq));
  limit_switch_model u_limit_switch_model (.fwdPressed(fwdPressed), .revPressed(revPressed),
    .normallyOpen(normallyOpen), .fwdTravelLimitIn(fwdTravelLimitIn), .revTravelLimitIn(revTravelLimitIn));

  // --------------------------------------------------------
  // Tasks
  // --------------------------------------------------------
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task waitClk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Holds the request until pready is seen at an edge; a hung slave ends the wait
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= wr;
    apbReq.paddr <= a;
    apbReq.pwdata <= d;
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (apbRsp.pready !== 1'b1 && n < 50);
    if (n >= 50)
      chk("pready", 1'b1, 1'b0);
    q = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, q);
  endtask

  // --------------------------------------------------------
  // Clock, reset and watchdog
  // --------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    test_done;
  end

  // --------------------------------------------------------
  // Tests
  // --------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    apbReq = '0;
    torqueRef = 12'sh000;
    moveFwd = 1'b0;
    moveRev = 1'b0;
    motorStopped = 1'b0;
    fwdPressed = 1'b1;
    revPressed = 1'b1;
    normallyOpen = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rdChk("CTRL", `OTL_CTRL, 32'h0000_0088);
    rdChk("TLIM", `OTL_TLIM, 32'h0320_0320);
    rdChk("ESTOP", `OTL_ESTOP, 32'h0320_0320);
    rdChk("IMASK", `OTL_IMASK, 32'h0000_0000);
    rdChk("unmapped", 8'h18, 32'h0000_0000);
    chk("pslverr", 1'b1, e);
    @(posedge clk);
    moveFwd <= 1'b1;
    moveRev <= 1'b1;
    torqueRef <= 12'sd100;
    waitClk(5);
    chk("fwdAllowed", 1'b1, fwdAllowed);
    chk("revAllowed", 1'b1, revAllowed);
    chk("torqueOut", 100, torqueOut);
    @(posedge clk);
    moveFwd <= 1'b0;
    moveRev <= 1'b0;
    $display("test defaults done");

    // Odd index pressed; index bit 1 uses a normally open switch with inverted mapping
    for (int i = 0; i < 8; i++)
    begin
      rev = i[2];
      no = i[1];
      pr = i[0];
      m = rev ? (no ? `OTL_MAP_REV_INV : `OTL_MAP_REV) : (no ? `OTL_MAP_FWD_INV : `OTL_MAP_FWD);
      wr(`OTL_CTRL, rev ? {24'h0, m, 4'h8} : {24'h0, 4'h8, m});
      @(posedge clk);
      normallyOpen <= no;
      fwdPressed <= pr;
      revPressed <= pr;
      torqueRef <= rev ? -12'sd100 : 12'sd100;
      waitClk(5);
      chk("allowed", !pr, rev ? revAllowed : fwdAllowed);
      chk("otherAllowed", 1'b1, rev ? fwdAllowed : revAllowed);
      chk("torqueOut", pr ? 0 : (rev ? -100 : 100), torqueOut);
    end
    $display("test mappings done");

    wr(`OTL_CTRL, 32'h0000_0082);
    @(posedge clk);
    normallyOpen <= 1'b0;
    fwdPressed <= 1'b0;
    waitClk(5);
    @(posedge clk);
    fwdPressed <= 1'b1;
    waitClk(3);
    chk("fwdAllowed early", 1'b1, fwdAllowed);
    waitClk(2);
    chk("fwdAllowed", 1'b0, fwdAllowed);
    $display("test sync done");

    // Modes 0, 1, 2, then mode 1 under torque control
    wr(`OTL_ESTOP, 32'h0320_0064);
    for (int j = 0; j < 4; j++)
    begin
      tq = (j == 3);
      md = (j == 3) ? 2'h1 : j[1:0];
      dec = (j == 1 || j == 2);
      wr(`OTL_CTRL, {19'h0, tq, `OTL_METHOD_BRAKE, md, 4'h8, `OTL_MAP_FWD});
      @(posedge clk);
      fwdPressed <= 1'b0;
      torqueRef <= 12'sd0;
      waitClk(5);
      @(posedge clk);
      fwdPressed <= 1'b1;
      moveFwd <= 1'b1;
      waitClk(5);
      chk("driveOn stop", dec, driveOn);
      chk("brakeOn", !dec, brakeOn);
      chk("torqueOut stop", dec ? -100 : 0, torqueOut);
      @(posedge clk);
      motorStopped <= 1'b1;
      moveFwd <= 1'b0;
      waitClk(4);
      chk("zeroClamp", j == 1, zeroClamp);
      chk("driveOn end", j == 1, driveOn);
      chk("torqueOut end", 0, torqueOut);
      @(posedge clk);
      fwdPressed <= 1'b0;
      motorStopped <= 1'b0;
      waitClk(5);
      chk("driveOn run", 1'b1, driveOn);
    end
    // Reverse stop in mode 2 decelerates with positive torque
    wr(`OTL_CTRL, 32'h0000_0638);
    @(posedge clk);
    revPressed <= 1'b0;
    waitClk(5);
    @(posedge clk);
    revPressed <= 1'b1;
    moveRev <= 1'b1;
    waitClk(5);
    chk("torqueOut rev stop", 100, torqueOut);
    chk("revAllowed stop", 1'b0, revAllowed);
    @(posedge clk);
    motorStopped <= 1'b1;
    moveRev <= 1'b0;
    waitClk(4);
    chk("driveOn rev coast", 1'b0, driveOn);
    @(posedge clk);
    revPressed <= 1'b0;
    motorStopped <= 1'b0;
    waitClk(5);
    chk("driveOn rev run", 1'b1, driveOn);
    $display("test stop modes done");

    wr(`OTL_CTRL, 32'h0000_4088);
    wr(`OTL_TLIM, 32'h012C_00C8);
    wr(`OTL_ESTOP, 32'h0320_0320);
    apb(1'b0, `OTL_ISTAT, 32'h0000_0000);
    wr(`OTL_IMASK, 32'h0000_0004);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      torqueRef <= refTab[k][11:0];
      waitClk(4);
      chk("torqueOut lim", outTab[k], torqueOut);
      chk("limitActive", k[0] == 1'b0 && k != 3, limitActive);
      chk("outputCircuits", {1'b0, k == 0 || k == 2, 1'b0}, outputCircuits);
    end
    chk("irq", 1'b1, irq);
    rdChk("ISTAT", `OTL_ISTAT, 32'h0000_0004);
    waitClk(2);
    chk("irq cleared", 1'b0, irq);
    wr(`OTL_IMASK, 32'h0000_0000);
    @(posedge clk);
    torqueRef <= 12'sd250;
    waitClk(4);
    chk("irq masked", 1'b0, irq);
    rdChk("STATUS", `OTL_STATUS, 32'h0000_0084);
    rdChk("ISTAT sticky", `OTL_ISTAT, 32'h0000_0004);
    wr(`OTL_ESTOP, 32'h0096_0320);
    waitClk(4);
    chk("torqueOut max", 150, torqueOut);
    chk("limitActive max", 1'b1, limitActive);
    $display("test torque limit done");
    test_done;
  end
endmodule // tb
